// ===== logic/shc_defines.svh
`ifndef SHC_DEFINES_SVH
`define SHC_DEFINES_SVH

`define SHC_CLK_NS        5
`define SHC_TICK_NS       1000
`define SHC_TICK_CYC      ((`SHC_TICK_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_T_LOW_NS      1000
`define SHC_SLOT_RECOVERY_TIME_NS      1000
`define SHC_LOW_TICKS     ((`SHC_T_LOW_NS + `SHC_TICK_NS - 1) / `SHC_TICK_NS)
`define SHC_REC_TICKS     ((`SHC_SLOT_RECOVERY_TIME_NS + `SHC_TICK_NS - 1) / `SHC_TICK_NS)
`define SHC_SLOT_STD_TICKS 65
`define SHC_RDV_STD_TICKS  15
`define SHC_SLOT_OD_TICKS  8
`define SHC_RDV_OD_TICKS   2

`define SHC_REG_CMD       2'h0
`define SHC_REG_STAT      2'h1
`define SHC_REG_CTRL      2'h2
`define SHC_CTRL_CLR_REF  0

`define SHC_CRC_POLY      8'h8C
`define SHC_CHAL_BYTES    4'h8
`define SHC_ADDR2         2'h2
`define SHC_ADDR1         2'h1

`define SHC_OP_WR_CHAL    8'h0C
`define SHC_OP_MAC_ANON   8'h36
`define SHC_OP_MAC_ID     8'h35
`define SHC_OP_CLR_SECRET 8'h5A
`define SHC_OP_NEXT_SHARE 8'h30
`define SHC_OP_NEXT_UNIQ  8'h33
`define SHC_OP_LOCK       8'h6A
`define SHC_OP_RD_MEM     8'hF0
`define SHC_OP_RD_CRC     8'hC3
`define SHC_OP_RD_ALL     8'h65
`define SHC_OP_RD_STAT    8'hAA
`define SHC_OP_WR_STAT    8'h55
`define SHC_OP_WR_PAD     8'h6C
`define SHC_OP_RD_PAD     8'h69
`define SHC_OP_COPY_PAD   8'h48
`define SHC_OP_OD_ON      8'h8B
`define SHC_OP_OD_OFF     8'h8D
`define SHC_OP_SOFT_RST   8'hBB

`endif

// ===== logic/shc_pkg.sv
package shc_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH, PH_REC} shc_phase_type;

    typedef struct packed {
        logic       crcclr;
        logic       opcode;
        logic       rd;
        logic [7:0] data;
    } shc_cmd_type;

    typedef struct packed {
        logic [7:0] crc;
    } shc_crc_type;

    typedef struct packed {
        shc_phase_type phase;
        logic [15:0]   div;
        logic [7:0]    tick_n;
        logic [2:0]    bit_n;
        logic [7:0]    shreg;
        logic          cur;
        logic          rd;
        logic          is_op;
        logic [7:0]    op;
        logic          overdrive;
        logic          chal_ok;
        logic [3:0]    chal_left;
        logic [1:0]    addr_left;
        logic [7:0]    addr_lo;
        logic [7:0]    addr_hi;
        logic          refused;
        logic [7:0]    rx;
        logic [10:0]   cmd;
        logic          rd_pend;
        logic [31:0]   rdata;
        logic          line_oe;
    } shc_state_type;

endpackage : shc_pkg

// ===== logic/shc_crc8.sv
`timescale 1ns/1ps
`default_nettype none
`include "shc_defines.svh"

module shc_crc8 #(
    parameter logic [7:0] POLY = `SHC_CRC_POLY
) (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       clr_in,
    input  wire logic       en_in,
    input  wire logic       bit_in,
    output logic [7:0]      crc_out
);

    shc_pkg::shc_crc_type st_q;
    shc_pkg::shc_crc_type st_d;
    logic                 fb;

    always_comb begin
        st_d = st_q;
        fb   = st_q.crc[0] ^ bit_in;
        if (clr_in) begin
            st_d.crc = 8'h00;
        end else if (en_in) begin
            // Reflected form: data enters at the low end, LSB first
            st_d.crc = (st_q.crc >> 1) ^ (fb ? POLY : 8'h00);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign crc_out = st_q.crc;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_crc_clear;
        clr_in |=> crc_out == 8'h00;
    endproperty
    a_crc_clear: assert property (p_crc_clear) else $error("crc not cleared");

    property p_crc_zero_hold;
        (crc_out == 8'h00 && en_in && !bit_in && !clr_in) |=> crc_out == 8'h00;
    endproperty
    a_crc_zero_hold: assert property (p_crc_zero_hold) else $error("crc moved on zero");

    property p_crc_one;
        (crc_out == 8'h00 && en_in && bit_in && !clr_in) |=> crc_out == POLY;
    endproperty
    a_crc_one: assert property (p_crc_one) else $error("crc wrong after one bit");

endmodule : shc_crc8
`default_nettype wire

// ===== logic/shc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "shc_defines.svh"

module shc_host #(
    parameter int TICK_CYC   = `SHC_TICK_CYC,
    parameter int LOW_TICKS  = `SHC_LOW_TICKS,
    parameter int REC_TICKS  = `SHC_REC_TICKS,
    parameter int SLOT_STD   = `SHC_SLOT_STD_TICKS,
    parameter int RDV_STD    = `SHC_RDV_STD_TICKS,
    parameter int SLOT_OD    = `SHC_SLOT_OD_TICKS,
    parameter int RDV_OD     = `SHC_RDV_OD_TICKS
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [1:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe_out
);

    localparam int LOW_CYC = LOW_TICKS * TICK_CYC;
    localparam int REC_CYC = REC_TICKS * TICK_CYC;

    shc_pkg::shc_state_type st_q;
    shc_pkg::shc_state_type st_d;
    shc_pkg::shc_cmd_type   cmd;
    logic                   tick;
    logic                   wr_cmd;
    logic                   start;
    logic                   samp;
    logic                   slot_end;
    logic                   byte_done;
    logic                   bit_v;
    logic [7:0]             slot_t;
    logic [7:0]             rdv_t;
    logic [7:0]             tick_nx;
    logic                   crc_en;
    logic                   crc_clr;
    logic [7:0]             crc_q;

    function automatic logic op_known(input logic [7:0] op);
        case (op)
            `SHC_OP_WR_CHAL, `SHC_OP_MAC_ANON, `SHC_OP_MAC_ID,
            `SHC_OP_CLR_SECRET, `SHC_OP_NEXT_SHARE, `SHC_OP_NEXT_UNIQ,
            `SHC_OP_LOCK, `SHC_OP_RD_MEM, `SHC_OP_RD_CRC, `SHC_OP_RD_ALL,
            `SHC_OP_RD_STAT, `SHC_OP_WR_STAT, `SHC_OP_WR_PAD,
            `SHC_OP_RD_PAD, `SHC_OP_COPY_PAD, `SHC_OP_OD_ON,
            `SHC_OP_OD_OFF, `SHC_OP_SOFT_RST: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : op_known

    function automatic logic op_needs_chal(input logic [7:0] op);
        case (op)
            `SHC_OP_MAC_ANON, `SHC_OP_MAC_ID,
            `SHC_OP_NEXT_SHARE, `SHC_OP_NEXT_UNIQ: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : op_needs_chal

    assign cmd     = shc_pkg::shc_cmd_type'(avs_writedata_in[10:0]);
    assign wr_cmd  = avs_write_in && avs_address_in == `SHC_REG_CMD;
    assign tick    = st_q.div == 16'(TICK_CYC - 1);
    assign tick_nx = 8'(st_q.tick_n + 8'h01);
    assign slot_t  = st_q.overdrive ? 8'(SLOT_OD) : 8'(SLOT_STD);
    assign rdv_t   = st_q.overdrive ? 8'(RDV_OD) : 8'(RDV_STD);

    always_comb begin
        st_d      = st_q;
        crc_en    = 1'b0;
        crc_clr   = 1'b0;
        start     = 1'b0;
        samp      = 1'b0;
        slot_end  = 1'b0;
        byte_done = 1'b0;
        bit_v     = st_q.cur;

        // Reads take one wait cycle so the data come from a register
        if (avs_read_in && !st_q.rd_pend) begin
            st_d.rd_pend = 1'b1;
            case (avs_address_in)
                `SHC_REG_CMD:  st_d.rdata = {21'h00_0000, st_q.cmd};
                `SHC_REG_STAT: st_d.rdata = {8'h00, crc_q, st_q.rx, 1'b0,
                                             st_q.addr_left, crc_q == 8'h00,
                                             st_q.refused, st_q.chal_ok,
                                             st_q.overdrive,
                                             st_q.phase != shc_pkg::PH_IDLE};
                `SHC_REG_CTRL: st_d.rdata = {16'h0000, st_q.addr_hi, st_q.addr_lo};
                default:       st_d.rdata = 32'h0000_0000;
            endcase
        end else begin
            st_d.rd_pend = 1'b0;
        end

        if (avs_write_in && avs_address_in == `SHC_REG_CTRL &&
            avs_writedata_in[`SHC_CTRL_CLR_REF]) begin
            st_d.refused = 1'b0;
        end

        if (st_q.phase != shc_pkg::PH_IDLE) begin
            st_d.div = tick ? 16'h0000 : 16'(st_q.div + 16'h0001);
            if (tick) begin
                st_d.tick_n = tick_nx;
            end
        end

        case (st_q.phase)
            shc_pkg::PH_IDLE: begin
                if (wr_cmd) begin
                    st_d.cmd = avs_writedata_in[10:0];
                    crc_clr  = cmd.crcclr || cmd.opcode;
                    // Unknown opcodes and unarmed hash commands never reach the line
                    if (cmd.opcode && (!op_known(cmd.data) ||
                        (op_needs_chal(cmd.data) && !st_q.chal_ok))) begin
                        st_d.refused = 1'b1;
                    end else begin
                        start        = 1'b1;
                        st_d.phase   = shc_pkg::PH_LOW;
                        st_d.div     = 16'h0000;
                        st_d.tick_n  = 8'h00;
                        st_d.bit_n   = 3'h0;
                        st_d.rd      = cmd.rd;
                        st_d.is_op   = cmd.opcode;
                        // Address and data bytes keep the opcode that owns them
                        st_d.op      = cmd.opcode ? cmd.data : st_q.op;
                        st_d.shreg   = cmd.rd ? 8'hFF : cmd.data;
                        st_d.cur     = cmd.rd | cmd.data[0];
                        st_d.line_oe = 1'b1;
                    end
                end
            end
            shc_pkg::PH_LOW: begin
                // A zero is held low for the whole slot; a one or a read is released
                if (tick && st_q.cur && tick_nx == 8'(LOW_TICKS)) begin
                    st_d.phase   = shc_pkg::PH_HIGH;
                    st_d.line_oe = 1'b0;
                end else if (tick && !st_q.cur && tick_nx == slot_t) begin
                    slot_end = 1'b1;
                end
            end
            shc_pkg::PH_HIGH: begin
                if (tick && st_q.rd && tick_nx == rdv_t) begin
                    samp     = 1'b1;
                    bit_v    = line_in;
                    st_d.cur = line_in;
                end
                if (tick && tick_nx == slot_t) begin
                    slot_end = 1'b1;
                end
            end
            shc_pkg::PH_REC: begin
                if (tick && tick_nx == 8'(REC_TICKS)) begin
                    if (st_q.bit_n == 3'h7) begin
                        byte_done  = 1'b1;
                        st_d.phase = shc_pkg::PH_IDLE;
                        st_d.div   = 16'h0000;
                        st_d.rx    = st_q.shreg;
                    end else begin
                        st_d.phase   = shc_pkg::PH_LOW;
                        st_d.div     = 16'h0000;
                        st_d.tick_n  = 8'h00;
                        st_d.bit_n   = 3'(st_q.bit_n + 3'h1);
                        st_d.cur     = st_q.rd | st_q.shreg[0];
                        st_d.line_oe = 1'b1;
                    end
                end
            end
            default: begin
                st_d.phase   = shc_pkg::PH_IDLE;
                st_d.line_oe = 1'b0;
            end
        endcase

        if (slot_end) begin
            st_d.phase   = shc_pkg::PH_REC;
            st_d.div     = 16'h0000;
            st_d.tick_n  = 8'h00;
            st_d.line_oe = 1'b0;
            st_d.shreg   = {bit_v, st_q.shreg[7:1]};
            crc_en       = 1'b1;
        end

        if (byte_done && st_q.is_op) begin
            st_d.addr_left = 2'h0;
            case (st_q.op)
                `SHC_OP_WR_CHAL: begin
                    st_d.chal_left = `SHC_CHAL_BYTES;
                    st_d.chal_ok   = 1'b0;
                end
                `SHC_OP_OD_ON:   st_d.overdrive = 1'b1;
                `SHC_OP_OD_OFF:  st_d.overdrive = 1'b0;
                `SHC_OP_SOFT_RST: begin
                    // Device comes back at standard speed with no challenge held
                    st_d.overdrive = 1'b0;
                    st_d.chal_ok   = 1'b0;
                    st_d.chal_left = 4'h0;
                end
                `SHC_OP_RD_MEM, `SHC_OP_RD_CRC, `SHC_OP_RD_ALL,
                `SHC_OP_RD_STAT, `SHC_OP_COPY_PAD:
                    st_d.addr_left = `SHC_ADDR2;
                `SHC_OP_WR_PAD, `SHC_OP_RD_PAD:
                    st_d.addr_left = `SHC_ADDR1;
                default: st_d.addr_left = 2'h0;
            endcase
        end else if (byte_done && !st_q.rd) begin
            if (st_q.addr_left != 2'h0) begin
                st_d.addr_left = 2'(st_q.addr_left - 2'h1);
                if (st_q.addr_left == `SHC_ADDR2 || st_q.op == `SHC_OP_WR_PAD ||
                    st_q.op == `SHC_OP_RD_PAD) begin
                    st_d.addr_lo = st_q.shreg;
                end else begin
                    st_d.addr_hi = st_q.shreg;
                end
            end else if (st_q.chal_left != 4'h0) begin
                st_d.chal_left = 4'(st_q.chal_left - 4'h1);
                st_d.chal_ok   = st_q.chal_left == 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    shc_crc8 #(
        .POLY (`SHC_CRC_POLY)
    ) u_crc (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .clr_in   (crc_clr),
        .en_in    (crc_en),
        .bit_in   (bit_v),
        .crc_out  (crc_q)
    );

    // A busy engine stalls command writes instead of dropping them
    assign avs_waitrequest_out = (avs_read_in && !st_q.rd_pend) ||
                                 (wr_cmd && st_q.phase != shc_pkg::PH_IDLE);
    assign avs_readdata_out    = st_q.rdata;
    assign line_out            = 1'b0;
    assign line_oe_out         = st_q.line_oe;

    int low_cyc;
    int hi_cyc;
    int slot_cyc;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            low_cyc  <= 0;
            hi_cyc   <= 0;
            slot_cyc <= 0;
        end else begin
            low_cyc  <= st_q.line_oe ? low_cyc + 1 : 0;
            hi_cyc   <= st_q.line_oe ? 0 : hi_cyc + 1;
            slot_cyc <= (st_d.phase == shc_pkg::PH_LOW && st_q.phase != shc_pkg::PH_LOW) ?
                        0 : slot_cyc + 1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_op_done(logic [7:0] code);
        byte_done && st_q.is_op && st_q.op == code;
    endsequence

    property p_open_low;
        $rose(st_q.line_oe) |-> $past(st_q.phase) inside {shc_pkg::PH_IDLE, shc_pkg::PH_REC};
    endproperty
    a_open_low: assert property (p_open_low) else $error("slot not opened from idle");

    property p_low_min;
        $fell(st_q.line_oe) |-> low_cyc >= LOW_CYC;
    endproperty
    a_low_min: assert property (p_low_min) else $error("low phase too short");

    property p_sample_rdv;
        samp |-> slot_cyc == (st_q.overdrive ? RDV_OD : RDV_STD) * TICK_CYC - 1;
    endproperty
    a_sample_rdv: assert property (p_sample_rdv) else $error("sample off delay");

    property p_slot_len;
        slot_end |-> slot_cyc == (st_q.overdrive ? SLOT_OD : SLOT_STD) * TICK_CYC - 1;
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("slot length wrong");

    property p_rec_min;
        $rose(st_q.line_oe) && $past(st_q.phase) == shc_pkg::PH_REC |-> hi_cyc >= REC_CYC;
    endproperty
    a_rec_min: assert property (p_rec_min) else $error("recovery too short");

    property p_chal_arm;
        s_op_done(`SHC_OP_WR_CHAL) |=> st_q.chal_left == `SHC_CHAL_BYTES && !st_q.chal_ok;
    endproperty
    a_chal_arm: assert property (p_chal_arm) else $error("challenge not armed");

    property p_mac_refused;
        (st_q.phase == shc_pkg::PH_IDLE && wr_cmd && cmd.opcode &&
         cmd.data == `SHC_OP_MAC_ANON && !st_q.chal_ok)
        |=> st_q.refused && st_q.phase == shc_pkg::PH_IDLE && !st_q.line_oe;
    endproperty
    a_mac_refused: assert property (p_mac_refused) else $error("MAC sent unarmed");

    property p_lsb_first;
        start && !cmd.rd |=> st_q.cur == $past(avs_writedata_in[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first bit not LSB");

    property p_addr_two;
        s_op_done(`SHC_OP_RD_MEM) |=> st_q.addr_left == `SHC_ADDR2;
    endproperty
    a_addr_two: assert property (p_addr_two) else $error("address count wrong");

    property p_od_follow;
        s_op_done(`SHC_OP_OD_ON) |=> st_q.overdrive ##1 st_q.overdrive;
    endproperty
    a_od_follow: assert property (p_od_follow) else $error("overdrive not taken");

endmodule : shc_host
`default_nettype wire

// ===== verif/shc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module shc_dev_model (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       line_in,
    input  wire logic       rd_mode_in,
    input  wire logic [7:0] resp_in,
    output logic            pull_out,
    output logic [7:0]      rx_out,
    output logic            od_out
);
    logic [7:0] sh_q;
    logic [7:0] cnt_q;
    logic [2:0] bit_q;
    logic       prev_q;
    logic       act_q;
    logic [7:0] byte_w;
    logic [7:0] hold_w;

    assign byte_w = {line_in, sh_q[7:1]};
    // Hold past the host sample point yet free the line well before slot end
    assign hold_w = od_out ? 8'h0C : 8'h64;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sh_q     <= 8'h00;
            cnt_q    <= 8'h00;
            bit_q    <= 3'h0;
            prev_q   <= 1'b1;
            act_q    <= 1'b0;
            pull_out <= 1'b0;
            rx_out   <= 8'h00;
            od_out   <= 1'b0;
        end else begin
            prev_q <= line_in;
            if (prev_q && !line_in && !act_q) begin
                act_q    <= 1'b1;
                cnt_q    <= 8'h00;
                pull_out <= rd_mode_in && !resp_in[bit_q];
            end else if (act_q) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == hold_w) begin
                    pull_out <= 1'b0;
                    act_q    <= 1'b0;
                end
                if (cnt_q == 8'h06) begin
                    sh_q  <= byte_w;
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        rx_out <= byte_w;
                        if (!rd_mode_in && byte_w == 8'h8B) od_out <= 1'b1;
                        if (!rd_mode_in && byte_w == 8'h8D) od_out <= 1'b0;
                        if (!rd_mode_in && byte_w == 8'hBB) od_out <= 1'b0;
                    end
                end
            end
        end
    end
endmodule : shc_dev_model

`default_nettype wire

// ===== verif/shc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none

module shc_host_tb;
    logic        clk;
    logic        reset;
    logic [1:0]  adr;
    logic        rd;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] rdata;
    logic        wreq;
    logic        oe;
    logic        pull;
    logic        rdm;
    logic [7:0]  resp;
    logic [7:0]  rx;
    logic        od;
    logic        prev_oe;
    logic        lo;
    wire         line = ~pull & (oe ? lo : 1'b1);
    int          errors = 0;
    int          checks = 0;
    int          slots = 0;

    shc_host #(.TICK_CYC(4)) shc_host_i (
        .clk_in(clk), .reset_in(reset), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .line_in(line), .line_out(lo), .line_oe_out(oe)
    );
    shc_dev_model shc_dev_model_i (
        .clk_in(clk), .reset_in(reset), .line_in(line), .rd_mode_in(rdm),
        .resp_in(resp), .pull_out(pull), .rx_out(rx), .od_out(od)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        prev_oe <= oe;
        if (oe === 1'b1 && prev_oe === 1'b0) slots++;
    end

    task automatic close_out;
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask : chk

    task automatic wait_ack;
        int n;
        n = 0;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n == 5000) errors++;
    endtask : wait_ack

    task automatic bus_wr(input logic [1:0] a, input logic [31:0] d);
        adr <= a;
        wd  <= d;
        wr  <= 1'b1;
        wait_ack();
        wr  <= 1'b0;
        @(posedge clk);
    endtask : bus_wr

    task automatic bus_rd(input logic [1:0] a, output logic [31:0] d);
        adr <= a;
        rd  <= 1'b1;
        wait_ack();
        d = rdata;
        rd  <= 1'b0;
        @(posedge clk);
    endtask : bus_rd

    task automatic send(input logic [10:0] c);
        logic [31:0] s;
        int          n;
        n = 0;
        bus_wr(2'h0, {21'h0, c});
        do begin
            bus_rd(2'h1, s);
            n++;
        end while (s[0] !== 1'b0 && n < 2000);
        if (n == 2000) errors++;
    endtask : send

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        end
        return c;
    endfunction : crc8

    task automatic t_reset;
        logic [31:0] s;
        bus_rd(2'h1, s);
        chk("stat_flags", 32'h0000_0000, s & 32'h0000_000F);
        bus_rd(2'h3, s);
        chk("unmapped", 32'h0000_0000, s);
    endtask : t_reset

    task automatic t_refuse;
        logic [31:0] s;
        int          n0;
        n0 = slots;
        send(11'h236);
        bus_rd(2'h1, s);
        chk("refused_mac", 32'h0000_0001, {31'h0, s[3]});
        chk("no_slots", n0, slots);
        bus_wr(2'h2, 32'h0000_0001);
        send(11'h200);
        bus_rd(2'h0, s);
        chk("cmd_readback", 32'h0000_0200, s);
        bus_rd(2'h1, s);
        chk("refused_unknown", 32'h0000_0001, {31'h0, s[3]});
        bus_wr(2'h2, 32'h0000_0001);
    endtask : t_refuse

    task automatic t_chal;
        logic [31:0] s;
        send(11'h20C);
        for (int i = 0; i < 8; i++) send({3'h0, 8'h10 + 8'(i)});
        chk("dev_rx", 32'h0000_0017, {24'h0, rx});
        bus_rd(2'h1, s);
        chk("chal_loaded", 32'h0000_0001, {31'h0, s[2]});
        send(11'h236);
        bus_rd(2'h1, s);
        chk("mac_taken", 32'h0000_0000, {31'h0, s[3]});
        send(11'h000);
        t_read(8'hC6);
        send(11'h235);
        send(11'h230);
        send(11'h233);
        send(11'h25A);
        send(11'h26A);
        chk("dev_lock", 32'h0000_006A, {24'h0, rx});
        bus_rd(2'h1, s);
        chk("secret_ops", 32'h0000_0000, {31'h0, s[3]});
        send(11'h2BB);
        bus_rd(2'h1, s);
        chk("chal_after_rst", 32'h0000_0000, {31'h0, s[2]});
    endtask : t_chal

    task automatic t_read(input logic [7:0] v);
        logic [31:0] s;
        rdm  <= 1'b1;
        resp <= v;
        send(11'h100);
        rdm  <= 1'b0;
        bus_rd(2'h1, s);
        chk("read_byte", {24'h0, v}, {24'h0, s[15:8]});
    endtask : t_read

    task automatic t_crc;
        logic [31:0] s;
        logic [7:0]  c;
        c = crc8(crc8(crc8(8'h00, 8'hF0), 8'h34), 8'h12);
        send(11'h2F0);
        send(11'h034);
        send(11'h012);
        bus_rd(2'h2, s);
        chk("target_addr", 32'h0000_1234, s & 32'h0000_FFFF);
        bus_rd(2'h1, s);
        chk("crc_cmd_addr", {24'h0, c}, {24'h0, s[23:16]});
        t_read(c);
        bus_rd(2'h1, s);
        chk("crc_residue", 32'h0000_0001, {31'h0, s[4]});
    endtask : t_crc

    task automatic t_pad;
        logic [31:0] s;
        logic [7:0]  c;
        c = crc8(crc8(8'h00, 8'h69), 8'h21);
        send(11'h26C);
        send(11'h05A);
        bus_rd(2'h2, s);
        chk("pad_addr", 32'h0000_125A, s & 32'h0000_FFFF);
        send(11'h669);
        send(11'h021);
        bus_rd(2'h2, s);
        chk("rdpad_addr", 32'h0000_1221, s & 32'h0000_FFFF);
        bus_rd(2'h1, s);
        chk("crc_clear_cmd", {24'h0, c}, {24'h0, s[23:16]});
    endtask : t_pad

    task automatic t_od;
        logic [31:0] s;
        logic [7:0]  op4 [4];
        send(11'h28B);
        bus_rd(2'h1, s);
        chk("od_on", 32'h0000_0001, {31'h0, s[1]});
        chk("dev_od", 32'h0000_0001, {31'h0, od});
        send(11'h05C);
        chk("od_rx", 32'h0000_005C, {24'h0, rx});
        t_read(8'h3C);
        op4 = '{8'hC3, 8'h65, 8'hAA, 8'h48};
        foreach (op4[i]) begin
            send({3'h2, op4[i]});
            bus_rd(2'h1, s);
            chk("addr_expect", 32'h0000_0002, {30'h0, s[6:5]});
        end
        send(11'h255);
        bus_rd(2'h1, s);
        chk("wr_stat_addr", 32'h0000_0000, {30'h0, s[6:5]});
        send(11'h28D);
        bus_rd(2'h1, s);
        chk("od_off", 32'h0000_0000, {31'h0, s[1]});
    endtask : t_od

    initial begin
        reset   = 1'b1;
        adr     = 2'h0;
        rd      = 1'b0;
        wr      = 1'b0;
        wd      = 32'h0000_0000;
        rdm     = 1'b0;
        resp    = 8'hA5;
        prev_oe = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_refuse();
        t_chal();
        t_read(8'hA5);
        t_crc();
        t_pad();
        t_od();
        close_out();
    end

    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule : shc_host_tb

`default_nettype wire
